//--- shared/status_pin_pkg.sv
package status_pin_pkg;
   // ******************************************
   // register byte addresses
   // ******************************************
   localparam logic [7:0] OFS_STATUS_PIN_CONFIG = 8'h00;
   localparam logic [7:0] OFS_STARTUP_LATCH_STATUS = 8'h04;
   localparam logic [7:0] OFS_PIN_LIVE_STATUS = 8'h08;
   localparam logic [7:0] OFS_SOFTWARE_SCRATCH = 8'h0C;
   localparam logic [7:0] OFS_OE_PIN_CONFIG = 8'h10;

   // ******************************************
   // status_pin_config fields
   // ******************************************
   localparam int BIT_OPEN_DRAIN = 12;
   localparam int BIT_TRISTATE = 11;
   localparam int BIT_PULLDOWN = 10;
   localparam int BIT_PULLUP = 9;
   localparam int BIT_POLARITY = 8;
   localparam int SEL_MSB = 4;
   localparam int SEL_W = 5;
   localparam logic RST_PULLUP = 1'b1;
   localparam logic RST_OTHER_BIT = 1'b0;
   localparam logic [4:0] RST_SEL = 5'h00;

   // ******************************************
   // status source select codes
   // ******************************************
   localparam logic [4:0] SEL_APLL_LOCK = 5'h00;
   localparam logic [4:0] SEL_DPLL_LOCK = 5'h01;
   localparam logic [4:0] SEL_LOS_REF0 = 5'h02;
   localparam logic [4:0] SEL_LOS_REF1 = 5'h03;
   localparam logic [4:0] SEL_LOS_XTAL = 5'h04;
   localparam logic [4:0] SEL_ACT_REF0 = 5'h05;
   localparam logic [4:0] SEL_ACT_REF1 = 5'h06;
   localparam logic [4:0] SEL_INVALID_REF0 = 5'h07;
   localparam logic [4:0] SEL_INVALID_REF1 = 5'h08;
   localparam logic [4:0] SEL_DEVICE_INT = 5'h09;
   localparam logic [4:0] SEL_DEVICE_READY = 5'h0A;
   localparam logic [4:0] SEL_CONST_LOW = 5'h1D;
   localparam logic [4:0] SEL_CONST_HIGH = 5'h1E;
   localparam logic [4:0] SEL_NO_POLARITY = 5'h1F;
   localparam logic [4:0] SEL_LIVE_LAST = 5'h04;

   // ******************************************
   // status register fields and pin sampling
   // ******************************************
   localparam int BIT_BOND_PAD = 7;
   localparam int LATCH_W = 6;
   localparam int BIT_LIVE_STATUS_PIN = 1;
   localparam int BIT_LIVE_OE_PIN = 0;
   localparam int BIT_OE_SELECT = 0;
   localparam logic RST_OE_SELECT = 1'b0;
   localparam int SYNC_W = 5;
   localparam int SYNC_STATUS_PIN = 0;
   localparam int SYNC_DATA_PIN = 1;
   localparam int SYNC_CLOCK_PIN = 2;
   localparam int SYNC_OE_PIN = 3;
   localparam int SYNC_BOND_PAD = 4;
   localparam logic [1:0] LATCH_SETTLE_CYCLES = 2'h2;
endpackage : status_pin_pkg

//--- hdl/status_pin_gpio.sv
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
// How it works
// - selects 0/1 give analog/digital lock
// - selects 2..4 give signal loss monitors
// - selects 5/6 give activity monitors
// - selects 7/8 give reference invalid
// - select 9 gives masked device interrupt
// - select A gives device ready
// - 1D drives low, 1E high, rest reserved
// - polarity bit inverts selected value
// - polarity ignored at select 1F
// - open drain drives low only, else floats
// - tristate bit floats the status pin
// - pull-down enable passes to pad
// - pull-up enable passes, resets to one
// - bit 7 shows bond pad level
// - pin levels latched once after startup
// - live pin bit valid selects 0..4 only
// - live enable-pin bit zero when deselected
// - scratch word freely read and written
module status_pin_gpio #(
   parameter int INT_W = 8
) (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // internal status sources, same clock
   input wire logic APLL_LOCK,
   input wire logic DPLL_LOCK,
   input wire logic SIGNAL_LOSS_MONITOR_0,
   input wire logic SIGNAL_LOSS_MONITOR_1,
   input wire logic SIGNAL_LOSS_MONITOR_XTAL,
   input wire logic ACTIVITY_MONITOR_0,
   input wire logic ACTIVITY_MONITOR_1,
   input wire logic REF_INVALID_0,
   input wire logic REF_INVALID_1,
   input wire logic [INT_W-1:0] DEVICE_INT_STATUS,
   input wire logic [INT_W-1:0] DEVICE_INT_ENABLE,
   input wire logic DEVICE_READY,
   // asynchronous pads
   input wire logic STATUS_PIN_I,
   input wire logic DATA_IO_PIN_I,
   input wire logic SERIAL_CLOCK_PIN_I,
   input wire logic OUTPUT_ENABLE_CHIP_SELECT_PIN,
   input wire logic BOND_PAD_VALUE,
   // status pin pad
   output logic STATUS_PIN_O,
   output logic STATUS_PIN_OE,
   output logic STATUS_PIN_PULLUP_EN,
   output logic STATUS_PIN_PULLDOWN_EN
);

   // ******************************************
   // state
   // ******************************************
   typedef struct packed {
      logic od;
      logic hiz;
      logic pd;
      logic pu;
      logic pol;
      logic [4:0] sel;
      logic oe_sel;
      logic [31:0] scratch;
      logic [status_pin_pkg::SYNC_W-1:0] sync1;
      logic [status_pin_pkg::SYNC_W-1:0] sync2;
      logic [status_pin_pkg::LATCH_W-1:0] latched;
      logic latch_done;
      logic [1:0] settle;
      logic pin_o;
      logic pin_oe;
      logic live;
      logic [31:0] rdata;
      logic err;
   } state_s;

   state_s st_reg;
   state_s st_next;

   logic setup_phase;
   logic write_access;
   logic selected;
   logic shaped;
   logic [15:0] cfg_word;
   logic [31:0] read_word;
   logic read_hit;

   assign setup_phase = PSEL && !PENABLE;
   assign write_access = PSEL && PENABLE && PWRITE;

   // ******************************************
   // source select
   // ******************************************
   always_comb begin
      case (st_reg.sel)
         status_pin_pkg::SEL_APLL_LOCK: selected = APLL_LOCK;
         status_pin_pkg::SEL_DPLL_LOCK: selected = DPLL_LOCK;
         status_pin_pkg::SEL_LOS_REF0: selected = SIGNAL_LOSS_MONITOR_0;
         status_pin_pkg::SEL_LOS_REF1: selected = SIGNAL_LOSS_MONITOR_1;
         status_pin_pkg::SEL_LOS_XTAL: selected = SIGNAL_LOSS_MONITOR_XTAL;
         status_pin_pkg::SEL_ACT_REF0: selected = ACTIVITY_MONITOR_0;
         status_pin_pkg::SEL_ACT_REF1: selected = ACTIVITY_MONITOR_1;
         status_pin_pkg::SEL_INVALID_REF0: selected = REF_INVALID_0;
         status_pin_pkg::SEL_INVALID_REF1: selected = REF_INVALID_1;
         status_pin_pkg::SEL_DEVICE_INT: begin
            selected = |(DEVICE_INT_STATUS & DEVICE_INT_ENABLE);
         end
         status_pin_pkg::SEL_DEVICE_READY: selected = DEVICE_READY;
         status_pin_pkg::SEL_CONST_LOW: selected = 1'b0;
         status_pin_pkg::SEL_CONST_HIGH: selected = 1'b1;
         // reserved codes present a quiet low
         default: selected = 1'b0;
      endcase
   end

   // polarity is applied before open drain, so it decides which level floats
   always_comb begin
      if (st_reg.sel == status_pin_pkg::SEL_NO_POLARITY) begin
         shaped = selected;
      end else begin
         shaped = selected ^ st_reg.pol;
      end
   end

   // ******************************************
   // register read mux
   // ******************************************
   always_comb begin
      cfg_word = 16'h0000;
      cfg_word[status_pin_pkg::BIT_OPEN_DRAIN] = st_reg.od;
      cfg_word[status_pin_pkg::BIT_TRISTATE] = st_reg.hiz;
      cfg_word[status_pin_pkg::BIT_PULLDOWN] = st_reg.pd;
      cfg_word[status_pin_pkg::BIT_PULLUP] = st_reg.pu;
      cfg_word[status_pin_pkg::BIT_POLARITY] = st_reg.pol;
      cfg_word[status_pin_pkg::SEL_MSB:0] = st_reg.sel;
   end

   // no read has a side effect; unused bits stay zero
   always_comb begin
      read_word = 32'h0000_0000;
      read_hit = 1'b1;
      if (PADDR == status_pin_pkg::OFS_STATUS_PIN_CONFIG) begin
         read_word[15:0] = cfg_word;
      end else if (PADDR == status_pin_pkg::OFS_STARTUP_LATCH_STATUS) begin
         read_word[status_pin_pkg::BIT_BOND_PAD] =
            st_reg.sync2[status_pin_pkg::SYNC_BOND_PAD];
         read_word[status_pin_pkg::LATCH_W-1:0] = st_reg.latched;
      end else if (PADDR == status_pin_pkg::OFS_PIN_LIVE_STATUS) begin
         if (st_reg.sel <= status_pin_pkg::SEL_LIVE_LAST) begin
            read_word[status_pin_pkg::BIT_LIVE_STATUS_PIN] = st_reg.live;
         end
         if (!st_reg.oe_sel) begin
            read_word[status_pin_pkg::BIT_LIVE_OE_PIN] =
               st_reg.sync2[status_pin_pkg::SYNC_OE_PIN];
         end
      end else if (PADDR == status_pin_pkg::OFS_SOFTWARE_SCRATCH) begin
         read_word = st_reg.scratch;
      end else if (PADDR == status_pin_pkg::OFS_OE_PIN_CONFIG) begin
         read_word[status_pin_pkg::BIT_OE_SELECT] = st_reg.oe_sel;
      end else begin
         read_hit = 1'b0;
      end
   end

   // ******************************************
   // next state
   // ******************************************
   always_comb begin
      st_next = st_reg;
      // first stage feeds only the second stage
      st_next.sync1 = {BOND_PAD_VALUE, OUTPUT_ENABLE_CHIP_SELECT_PIN,
                       SERIAL_CLOCK_PIN_I, DATA_IO_PIN_I, STATUS_PIN_I};
      st_next.sync2 = st_reg.sync1;

      // capture only once the synchroniser has filled after reset
      if (!st_reg.latch_done) begin
         if (st_reg.settle == status_pin_pkg::LATCH_SETTLE_CYCLES) begin
            st_next.latched = {2'b00,
               st_reg.sync2[status_pin_pkg::SYNC_OE_PIN:status_pin_pkg::SYNC_STATUS_PIN]};
            st_next.latch_done = 1'b1;
         end else begin
            st_next.settle = st_reg.settle + 2'h1;
         end
      end

      // pin drive is registered so the pad never sees a decode glitch
      st_next.live = shaped;
      if (st_reg.od) begin
         st_next.pin_o = 1'b0;
         st_next.pin_oe = !st_reg.hiz && !shaped;
      end else begin
         st_next.pin_o = shaped;
         st_next.pin_oe = !st_reg.hiz;
      end

      // apb: read data sampled in setup, writes land in access
      if (setup_phase) begin
         st_next.rdata = read_word;
         st_next.err = !read_hit;
      end
      if (write_access) begin
         if (PADDR == status_pin_pkg::OFS_STATUS_PIN_CONFIG) begin
            st_next.od = PWDATA[status_pin_pkg::BIT_OPEN_DRAIN];
            st_next.hiz = PWDATA[status_pin_pkg::BIT_TRISTATE];
            st_next.pd = PWDATA[status_pin_pkg::BIT_PULLDOWN];
            st_next.pu = PWDATA[status_pin_pkg::BIT_PULLUP];
            st_next.pol = PWDATA[status_pin_pkg::BIT_POLARITY];
            st_next.sel = PWDATA[status_pin_pkg::SEL_MSB:0];
         end else if (PADDR == status_pin_pkg::OFS_SOFTWARE_SCRATCH) begin
            st_next.scratch = PWDATA;
         end else if (PADDR == status_pin_pkg::OFS_OE_PIN_CONFIG) begin
            st_next.oe_sel = PWDATA[status_pin_pkg::BIT_OE_SELECT];
         end
      end
   end

   // ******************************************
   // registers
   // ******************************************
   always_ff @(posedge MCLK) begin
      if (RST) begin
         st_reg.od <= status_pin_pkg::RST_OTHER_BIT;
         st_reg.hiz <= status_pin_pkg::RST_OTHER_BIT;
         st_reg.pd <= status_pin_pkg::RST_OTHER_BIT;
         st_reg.pu <= status_pin_pkg::RST_PULLUP;
         st_reg.pol <= status_pin_pkg::RST_OTHER_BIT;
         st_reg.sel <= status_pin_pkg::RST_SEL;
         st_reg.oe_sel <= status_pin_pkg::RST_OE_SELECT;
         st_reg.scratch <= 32'h0000_0000;
         st_reg.sync1 <= '0;
         st_reg.sync2 <= '0;
         st_reg.latched <= '0;
         st_reg.latch_done <= 1'b0;
         st_reg.settle <= 2'h0;
         st_reg.pin_o <= 1'b0;
         st_reg.pin_oe <= 1'b0;
         st_reg.live <= 1'b0;
         st_reg.rdata <= 32'h0000_0000;
         st_reg.err <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ******************************************
   // outputs
   // ******************************************
   assign PRDATA = st_reg.rdata;
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL && PENABLE && st_reg.err;
   assign STATUS_PIN_O = st_reg.pin_o;
   assign STATUS_PIN_OE = st_reg.pin_oe;
   assign STATUS_PIN_PULLUP_EN = st_reg.pu;
   assign STATUS_PIN_PULLDOWN_EN = st_reg.pd;

   // ******************************************
   // checks
   // ******************************************
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   logic push_pull_on;
   assign push_pull_on = !st_reg.od && !st_reg.hiz;

   AST_APLL: assert property (
      (st_reg.sel == status_pin_pkg::SEL_APLL_LOCK && !st_reg.pol && push_pull_on)
      |=> STATUS_PIN_O == $past(APLL_LOCK))
      else $error("status pin does not follow analog lock");

   AST_DPLL_INV: assert property (
      (st_reg.sel == status_pin_pkg::SEL_DPLL_LOCK && st_reg.pol && push_pull_on)
      |=> STATUS_PIN_O == !$past(DPLL_LOCK))
      else $error("inverted digital lock wrong");

   AST_LOS_XTAL: assert property (
      (st_reg.sel == status_pin_pkg::SEL_LOS_XTAL && !st_reg.pol && push_pull_on)
      |=> STATUS_PIN_O == $past(SIGNAL_LOSS_MONITOR_XTAL))
      else $error("crystal loss not routed");

   AST_ACT1: assert property (
      (st_reg.sel == status_pin_pkg::SEL_ACT_REF1 && !st_reg.pol && push_pull_on)
      |=> STATUS_PIN_O == $past(ACTIVITY_MONITOR_1))
      else $error("activity monitor 1 not routed");

   AST_INVALID0: assert property (
      (st_reg.sel == status_pin_pkg::SEL_INVALID_REF0 && !st_reg.pol && push_pull_on)
      |=> STATUS_PIN_O == $past(REF_INVALID_0))
      else $error("reference invalid 0 not routed");

   AST_INT: assert property (
      (st_reg.sel == status_pin_pkg::SEL_DEVICE_INT && !st_reg.pol && push_pull_on)
      |=> STATUS_PIN_O == $past(|(DEVICE_INT_STATUS & DEVICE_INT_ENABLE)))
      else $error("masked interrupt not routed");

   AST_READY: assert property (
      (st_reg.sel == status_pin_pkg::SEL_DEVICE_READY && !st_reg.pol && push_pull_on)
      |=> STATUS_PIN_O == $past(DEVICE_READY))
      else $error("device ready not routed");

   AST_CONST: assert property (
      (st_reg.sel == status_pin_pkg::SEL_CONST_HIGH && !st_reg.pol && push_pull_on)
      [*2] |-> STATUS_PIN_O)
      else $error("constant high not driven");

   AST_CONST_LOW: assert property (
      (st_reg.sel == status_pin_pkg::SEL_CONST_LOW && st_reg.pol && push_pull_on)
      |=> STATUS_PIN_O)
      else $error("inverted constant low not driven high");

   AST_NO_POL: assert property (
      (st_reg.sel == status_pin_pkg::SEL_NO_POLARITY && st_reg.pol && push_pull_on)
      |=> !STATUS_PIN_O)
      else $error("polarity applied at select 1F");

   AST_OPEN_DRAIN: assert property (
      $past(st_reg.od) |-> !STATUS_PIN_O && (STATUS_PIN_OE == !$past(shaped)
      || $past(st_reg.hiz)))
      else $error("open drain drives high or wrong level");

   AST_TRISTATE: assert property (
      st_reg.hiz |=> !STATUS_PIN_OE)
      else $error("tristate pin still driven");

   AST_PULLDOWN: assert property (
      (write_access && PADDR == status_pin_pkg::OFS_STATUS_PIN_CONFIG)
      |=> STATUS_PIN_PULLDOWN_EN == $past(PWDATA[status_pin_pkg::BIT_PULLDOWN]))
      else $error("pull-down enable not taken from write");

   AST_PULLUP: assert property (
      (write_access && PADDR == status_pin_pkg::OFS_STATUS_PIN_CONFIG)
      |=> STATUS_PIN_PULLUP_EN == $past(PWDATA[status_pin_pkg::BIT_PULLUP]))
      else $error("pull-up enable not taken from write");

   AST_LATCH_ONCE: assert property (
      st_reg.latch_done |=> st_reg.latch_done && $stable(st_reg.latched))
      else $error("startup latch changed");

   AST_LATCH_TIME: assert property (
      $rose(!RST) |-> ##[1:4] st_reg.latch_done)
      else $error("startup latch late");

   AST_LIVE_ZERO: assert property (
      (setup_phase && PADDR == status_pin_pkg::OFS_PIN_LIVE_STATUS
       && st_reg.sel > status_pin_pkg::SEL_LIVE_LAST)
      |=> !PRDATA[status_pin_pkg::BIT_LIVE_STATUS_PIN])
      else $error("live pin bit not zero");

   AST_OE_ZERO: assert property (
      (setup_phase && PADDR == status_pin_pkg::OFS_PIN_LIVE_STATUS && st_reg.oe_sel)
      |=> !PRDATA[status_pin_pkg::BIT_LIVE_OE_PIN])
      else $error("live enable-pin bit not zero");

   AST_SCRATCH: assert property (
      (write_access && PADDR == status_pin_pkg::OFS_SOFTWARE_SCRATCH)
      |=> st_reg.scratch == $past(PWDATA))
      else $error("scratch write lost");

   AST_RESERVED: assert property (
      (setup_phase && PADDR == status_pin_pkg::OFS_STATUS_PIN_CONFIG)
      |=> PRDATA[31:13] == 19'h0 && PRDATA[7:5] == 3'h0)
      else $error("reserved bits not zero");

   COV_OPEN_DRAIN: cover property (st_reg.od && !st_reg.hiz ##1 !STATUS_PIN_OE);
   COV_INT: cover property (st_reg.sel == status_pin_pkg::SEL_DEVICE_INT ##1 STATUS_PIN_O);
   COV_SCRATCH: cover property (write_access && PADDR == status_pin_pkg::OFS_SOFTWARE_SCRATCH);
   COV_BAD_ADDR: cover property (PSLVERR);

endmodule : status_pin_gpio

//--- testbench/status_board_model.sv
`timescale 1ns/1ps
// ******************************************
// board side of the status pin
// ******************************************
// with no drive and no pull the pad drifts, so the model toggles it
module status_board_model (
   // pad controls from the device
   input wire logic mclk,
   input wire logic pin_o,
   input wire logic pin_oe,
   input wire logic pullup_en,
   input wire logic pulldown_en,
   // resolved pad level
   output logic pad
);
   logic last_level = 1'b0;

   always_comb begin
      if (pin_oe) begin
         pad = pin_o;
      end else if (pullup_en) begin
         pad = 1'b1;
      end else if (pulldown_en) begin
         pad = 1'b0;
      end else begin
         pad = ~last_level;
      end
   end

   always_ff @(posedge mclk) begin
      last_level <= pad;
   end
endmodule : status_board_model

//--- testbench/tb.sv
`timescale 1ns/1ps
module tb;
   // ******************************************
   // clock, reset, bus and sources
   // ******************************************
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, STATUS_PIN_O, STATUS_PIN_OE, pu_en, pd_en, pad;
   logic [10:0] src = 11'h001;
   logic [7:0] int_st = 8'h00;
   logic [7:0] int_en = 8'h10;
   logic data_pin = 1'b1, clk_pin = 1'b0, oe_pin = 1'b1, bond = 1'b1;
   int fails = 0;
   int check_count = 0;

   always #5 MCLK = ~MCLK;

   status_pin_gpio #(.INT_W(8)) uut (
      .MCLK(MCLK), .RST(RST), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .APLL_LOCK(src[0]), .DPLL_LOCK(src[1]), .SIGNAL_LOSS_MONITOR_0(src[2]),
      .SIGNAL_LOSS_MONITOR_1(src[3]), .SIGNAL_LOSS_MONITOR_XTAL(src[4]),
      .ACTIVITY_MONITOR_0(src[5]), .ACTIVITY_MONITOR_1(src[6]), .REF_INVALID_0(src[7]),
      .REF_INVALID_1(src[8]), .DEVICE_INT_STATUS(int_st), .DEVICE_INT_ENABLE(int_en),
      .DEVICE_READY(src[10]), .STATUS_PIN_I(pad), .DATA_IO_PIN_I(data_pin),
      .SERIAL_CLOCK_PIN_I(clk_pin), .OUTPUT_ENABLE_CHIP_SELECT_PIN(oe_pin),
      .BOND_PAD_VALUE(bond), .STATUS_PIN_O(STATUS_PIN_O), .STATUS_PIN_OE(STATUS_PIN_OE),
      .STATUS_PIN_PULLUP_EN(pu_en), .STATUS_PIN_PULLDOWN_EN(pd_en)
   );

   status_board_model board (
      .mclk(MCLK), .pin_o(STATUS_PIN_O), .pin_oe(STATUS_PIN_OE), .pullup_en(pu_en),
      .pulldown_en(pd_en), .pad(pad)
   );

   // ******************************************
   // shared tasks
   // ******************************************
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task automatic settle(input int n);
      repeat (n) @(posedge MCLK);
      #1;
   endtask : settle

   // request held until pready is seen high, released at that edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge MCLK);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge MCLK);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge MCLK);
      end while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp,
                      input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0, rd, err);
      check(nm, exp, rd);
      check({nm, "_err"}, {31'h0, exp_err}, {31'h0, err});
   endtask : rdc

   function automatic logic exp_pin(input logic [4:0] s, input logic pol);
      logic v;
      if (s <= 5'h08 || s == 5'h0A) begin
         v = src[s];
      end else if (s == 5'h09) begin
         v = |(int_st & int_en);
      end else begin
         v = (s == 5'h1E);
      end
      return (s == 5'h1F) ? v : v ^ pol;
   endfunction : exp_pin

   // ******************************************
   // scenarios
   // ******************************************
   task automatic test_startup();
      settle(5);
      rdc("startup", 8'h04, 32'h8B, 1'b0);
      rdc("live", 8'h08, 32'h3, 1'b0);
      @(posedge MCLK);
      bond <= 1'b0;
      data_pin <= 1'b0;
      oe_pin <= 1'b0;
      settle(4);
      rdc("startup_held", 8'h04, 32'h0B, 1'b0);
      wr(8'h04, 32'hFFFF_FFFF);
      rdc("startup_ro", 8'h04, 32'h0B, 1'b0);
      rdc("live_oe0", 8'h08, 32'h2, 1'b0);
      oe_pin <= 1'b1;
      settle(4);
      rdc("live_oe1", 8'h08, 32'h3, 1'b0);
      wr(8'h10, 32'h1);
      rdc("live_oe_off", 8'h08, 32'h2, 1'b0);
      wr(8'h10, 32'h0);
   endtask : test_startup

   task automatic test_regs();
      rdc("cfg_rst", 8'h00, 32'h200, 1'b0);
      check("pu_rst", 32'h1, {31'h0, pu_en});
      rdc("scr_rst", 8'h0C, 32'h0, 1'b0);
      wr(8'h0C, 32'hA5C3_1E7F);
      rdc("scr_a", 8'h0C, 32'hA5C3_1E7F, 1'b0);
      wr(8'h0C, 32'h5A3C_E180);
      wr(8'h20, 32'hFFFF_FFFF);
      rdc("scr_b", 8'h0C, 32'h5A3C_E180, 1'b0);
      rdc("unmapped", 8'h20, 32'h0, 1'b1);
      wr(8'h00, 32'hFFFF_FFFF);
      rdc("cfg_rsv", 8'h00, 32'h1F1F, 1'b0);
      wr(8'h00, 32'h200);
   endtask : test_regs

   task automatic test_select();
      logic [4:0] codes [15];
      logic [31:0] rd;
      logic err, e;
      codes = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                5'h0A, 5'h0B, 5'h1D, 5'h1E, 5'h1F};
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 15; i++) begin
            for (int k = 0; k < 2; k++) begin
               apb(1'b1, 8'h00, {19'h0, 4'h1, p[0], 3'h0, codes[i]}, rd, err);
               src <= k[0] ? (11'h001 << codes[i]) : ~(11'h001 << codes[i]);
               int_st <= k[0] ? 8'h10 : 8'hEF;
               settle(2);
               e = exp_pin(codes[i], p[0]);
               check("pin", {31'h0, e}, {31'h0, STATUS_PIN_O});
               check("pin_oe", 32'h1, {31'h0, STATUS_PIN_OE});
               apb(1'b0, 8'h08, 32'h0, rd, err);
               check("live", {30'h0, (codes[i] <= 5'h04) & e, 1'b1}, rd);
            end
         end
      end
   endtask : test_select

   task automatic test_drive();
      for (int j = 0; j < 4; j++) begin
         wr(8'h00, {19'h0, 4'h9, j[1], 3'h0, j[0] ? 5'h1E : 5'h1D});
         settle(2);
         check("od_oe", {31'h0, ~(j[0] ^ j[1])}, {31'h0, STATUS_PIN_OE});
         check("od_o", 32'h0, {31'h0, STATUS_PIN_O});
         check("od_pad", {31'h0, j[0] ^ j[1]}, {31'h0, pad});
      end
      wr(8'h00, {19'h0, 4'h5, 1'b0, 3'h0, 5'h1E});
      settle(2);
      check("tri_oe", 32'h0, {31'h0, STATUS_PIN_OE});
      wr(8'h00, {19'h0, 4'h6, 1'b0, 3'h0, 5'h1E});
      settle(2);
      check("pulls", 32'h1, {30'h0, pu_en, pd_en});
      check("pd_pad", 32'h0, {31'h0, pad});
      wr(8'h00, 32'h200);
   endtask : test_drive

   // ******************************************
   // main sequence and watchdog
   // ******************************************
   initial begin
      repeat (16) @(posedge MCLK);
      RST <= 1'b0;
      test_startup();
      test_regs();
      test_select();
      test_drive();
      report_and_stop();
   end

   initial begin
      #100000;
      fails++;
      report_and_stop();
   end
endmodule : tb
